// ### rtl/psc_cfg.svh
// register indices, field positions and reset values of the packet statistics block
// assumes a 32-bit APB slave with word-aligned registers, byte address = 4 * index
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

`define PSC_ADDR_W 16
`define PSC_IDX_W 14
`define PSC_DATA_W 32
`define PSC_REG_W 16

// match data words
`define PSC_IDX_DA_LOW 14'h0628
`define PSC_IDX_DA_MID 14'h0629
`define PSC_IDX_DA_UPPER 14'h062a
// counters
`define PSC_IDX_TX_LOW 14'h0639
`define PSC_IDX_TX_HIGH 14'h063a
`define PSC_IDX_TX_CRC 14'h063b
`define PSC_IDX_RX_LOW 14'h063c
`define PSC_IDX_RX_HIGH 14'h063d
`define PSC_IDX_RX_CRC 14'h063e
// ordered read sequences that clear the counters
`define PSC_IDX_TX_SEQ0 14'h060f
`define PSC_IDX_TX_SEQ1 14'h0610
`define PSC_IDX_TX_SEQ2 14'h0611
`define PSC_IDX_RX_SEQ0 14'h0612
`define PSC_IDX_RX_SEQ1 14'h0613
`define PSC_IDX_RX_SEQ2 14'h0614
// interrupt registers
`define PSC_IDX_IRQ_STATUS 14'h0700
`define PSC_IDX_IRQ_ENABLE 14'h0701
`define PSC_IDX_IRQ_CLEAR 14'h0702

`define PSC_IRQ_W 6
`define PSC_IRQ_TX_CLR 0
`define PSC_IRQ_RX_CLR 1
`define PSC_IRQ_TX_WRAP 2
`define PSC_IRQ_RX_WRAP 3
`define PSC_IRQ_TX_CRC 4
`define PSC_IRQ_RX_CRC 5

`define PSC_RST_REG 16'h0000
`define PSC_RST_IRQ 6'h00
`define PSC_RST_DATA 32'h0000_0000

`endif

// ### rtl/psc_counter.sv
// packet event counter with synchronous clear and wrap pulse
// assumes single clock, synchronous active-low reset
`default_nettype none
module psc_counter #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // control
   input wire logic i_inc,
   input wire logic i_clr,
   // status
   output logic [W-1:0] o_count,
   output logic o_wrap
);
   // an increment in the clearing cycle is kept
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_count <= '0;
      end else if (i_inc) begin
         o_count <= i_clr ? W'(1) : o_count + W'(1);
      end else if (i_clr) begin
         o_count <= '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_wrap <= 1'b0;
      end else begin
         o_wrap <= i_inc && !i_clr && (&o_count);
      end
   end
endmodule
`default_nettype wire

// ### rtl/psc_pkg.sv
// types shared by the packet statistics block
// assumes nothing beyond the configuration header
`default_nettype none
package psc_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_FIRST,
      SEQ_SECOND
   } psc_seq_t;
endpackage
`default_nettype wire

// ### rtl/psc_regs.sv
// packet statistics and destination match registers on an APB slave
// assumes packet event strobes are one-cycle pulses synchronous to i_clk
//
// Decided for this implementation: the APB register port.
`include "psc_cfg.svh"
`default_nettype none

// Summary of operation
// - read/write match data bits 47:32
// - transmit count low half readable
// - transmit count high half readable
// - 16-bit transmit CRC error counter readable
// - ordered reads 60F,610,611 clear transmit counters
// - receive count low half readable
// - receive count high half readable
// - ordered reads 612,613,614 clear receive counters
// - receive CRC error counter, cleared with receive
// - read/write match data bits 15:0
module psc_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`PSC_ADDR_W-1:0] i_paddr,
   input wire logic [`PSC_DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [`PSC_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // packet events
   input wire logic i_tx_pkt_done,
   input wire logic i_tx_pkt_crc_err,
   input wire logic i_rx_pkt_done,
   input wire logic i_rx_pkt_crc_err,
   // destination address check
   input wire logic i_rx_da_valid,
   input wire logic [47:0] i_rx_da,
   output logic o_da_match,
   output logic [47:0] o_match_data,
   // interrupt
   output logic o_irq
);
   logic [`PSC_IDX_W-1:0] idx;
   logic access;
   logic done;
   logic rd_done;
   logic wr_done;
   logic mapped;
   logic [`PSC_REG_W-1:0] da_low_reg;
   logic [`PSC_REG_W-1:0] da_mid_reg;
   logic [`PSC_REG_W-1:0] da_upper_reg;
   logic [`PSC_IRQ_W-1:0] irq_status_reg;
   logic [`PSC_IRQ_W-1:0] irq_status_next;
   logic [`PSC_IRQ_W-1:0] irq_enable_reg;
   logic [`PSC_IRQ_W-1:0] irq_event;
   logic [`PSC_IRQ_W-1:0] irq_clear;
   psc_pkg::psc_seq_t tx_seq_reg;
   psc_pkg::psc_seq_t rx_seq_reg;
   logic tx_clr;
   logic rx_clr;
   logic [31:0] tx_cnt;
   logic [31:0] rx_cnt;
   logic [15:0] tx_err_cnt;
   logic [15:0] rx_err_cnt;
   logic tx_wrap;
   logic rx_wrap;
   logic tx_inc;
   logic rx_inc;
   logic tx_err_inc;
   logic rx_err_inc;
   logic [`PSC_DATA_W-1:0] rdata;

   // merge a write into a 16-bit register by byte lane
   function automatic logic [`PSC_REG_W-1:0] lane_merge(input logic [`PSC_REG_W-1:0] old,
                                                         input logic [`PSC_DATA_W-1:0] wd,
                                                         input logic [3:0] strb);
      lane_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   endfunction

   // advance one ordered-read tracker on a completed access
   function automatic psc_pkg::psc_seq_t seq_step(input psc_pkg::psc_seq_t cur,
                                                   input logic rd,
                                                   input logic [`PSC_IDX_W-1:0] a,
                                                   input logic [`PSC_IDX_W-1:0] a0,
                                                   input logic [`PSC_IDX_W-1:0] a1);
      if (rd && a == a0) begin
         seq_step = psc_pkg::SEQ_FIRST;
      end else if (rd && a == a1 && cur == psc_pkg::SEQ_FIRST) begin
         seq_step = psc_pkg::SEQ_SECOND;
      end else begin
         seq_step = psc_pkg::SEQ_IDLE;
      end
   endfunction

   assign idx = i_paddr[`PSC_IDX_W+1:2];
   assign access = i_psel && i_penable;
   assign done = access && o_pready;
   assign rd_done = done && !i_pwrite;
   assign wr_done = done && i_pwrite && mapped;

   // address decode and read mux
   always_comb begin
      mapped = (i_paddr[1:0] == 2'b00);
      rdata = `PSC_RST_DATA;
      case (idx)
         `PSC_IDX_DA_LOW: rdata[15:0] = da_low_reg;
         `PSC_IDX_DA_MID: rdata[15:0] = da_mid_reg;
         `PSC_IDX_DA_UPPER: rdata[15:0] = da_upper_reg;
         `PSC_IDX_TX_LOW: rdata[15:0] = tx_cnt[15:0];
         `PSC_IDX_TX_HIGH: rdata[15:0] = tx_cnt[31:16];
         `PSC_IDX_TX_CRC: rdata[15:0] = tx_err_cnt;
         `PSC_IDX_RX_LOW: rdata[15:0] = rx_cnt[15:0];
         `PSC_IDX_RX_HIGH: rdata[15:0] = rx_cnt[31:16];
         `PSC_IDX_RX_CRC: rdata[15:0] = rx_err_cnt;
         `PSC_IDX_IRQ_STATUS: rdata[`PSC_IRQ_W-1:0] = irq_status_reg;
         `PSC_IDX_IRQ_ENABLE: rdata[`PSC_IRQ_W-1:0] = irq_enable_reg;
         `PSC_IDX_IRQ_CLEAR, `PSC_IDX_TX_SEQ0, `PSC_IDX_TX_SEQ1, `PSC_IDX_TX_SEQ2,
         `PSC_IDX_RX_SEQ0, `PSC_IDX_RX_SEQ1, `PSC_IDX_RX_SEQ2: rdata = `PSC_RST_DATA;
         default: mapped = 1'b0;
      endcase
   end

   // one wait state, then answer
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_pready <= 1'b0;
         o_prdata <= `PSC_RST_DATA;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= access && !o_pready;
         if (access && !o_pready) begin
            o_prdata <= (mapped && !i_pwrite) ? rdata : `PSC_RST_DATA;
            o_pslverr <= !mapped;
         end else begin
            o_pslverr <= 1'b0;
         end
      end
   end

   // match data words
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         da_low_reg <= `PSC_RST_REG;
         da_mid_reg <= `PSC_RST_REG;
         da_upper_reg <= `PSC_RST_REG;
      end else if (wr_done) begin
         if (idx == `PSC_IDX_DA_LOW) begin
            da_low_reg <= lane_merge(da_low_reg, i_pwdata, i_pstrb);
         end
         if (idx == `PSC_IDX_DA_MID) begin
            da_mid_reg <= lane_merge(da_mid_reg, i_pwdata, i_pstrb);
         end
         if (idx == `PSC_IDX_DA_UPPER) begin
            da_upper_reg <= lane_merge(da_upper_reg, i_pwdata, i_pstrb);
         end
      end
   end

   // destination match against the 48-bit value
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_da_match <= 1'b0;
         o_match_data <= '0;
      end else begin
         o_match_data <= {da_upper_reg, da_mid_reg, da_low_reg};
         o_da_match <= i_rx_da_valid && (i_rx_da == {da_upper_reg, da_mid_reg, da_low_reg});
      end
   end

   // ordered read trackers
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         tx_seq_reg <= psc_pkg::SEQ_IDLE;
         rx_seq_reg <= psc_pkg::SEQ_IDLE;
      end else if (done) begin
         tx_seq_reg <= seq_step(tx_seq_reg, !i_pwrite, idx, `PSC_IDX_TX_SEQ0,
                                `PSC_IDX_TX_SEQ1);
         rx_seq_reg <= seq_step(rx_seq_reg, !i_pwrite, idx, `PSC_IDX_RX_SEQ0,
                                `PSC_IDX_RX_SEQ1);
      end
   end

   // third read in order clears its group
   assign tx_clr = rd_done && idx == `PSC_IDX_TX_SEQ2
                   && tx_seq_reg == psc_pkg::SEQ_SECOND;
   assign rx_clr = rd_done && idx == `PSC_IDX_RX_SEQ2
                   && rx_seq_reg == psc_pkg::SEQ_SECOND;
   assign tx_inc = i_tx_pkt_done;
   assign rx_inc = i_rx_pkt_done;
   assign tx_err_inc = i_tx_pkt_done && i_tx_pkt_crc_err;
   assign rx_err_inc = i_rx_pkt_done && i_rx_pkt_crc_err;

   psc_counter #(.W(32)) u_tx_cnt (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_inc(tx_inc), .i_clr(tx_clr),
      .o_count(tx_cnt), .o_wrap(tx_wrap)
   );
   psc_counter #(.W(32)) u_rx_cnt (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_inc(rx_inc), .i_clr(rx_clr),
      .o_count(rx_cnt), .o_wrap(rx_wrap)
   );
   psc_counter #(.W(16)) u_tx_err (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_inc(tx_err_inc), .i_clr(tx_clr),
      .o_count(tx_err_cnt), .o_wrap()
   );
   psc_counter #(.W(16)) u_rx_err (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_inc(rx_err_inc), .i_clr(rx_clr),
      .o_count(rx_err_cnt), .o_wrap()
   );

   // interrupt events, set wins over clear
   always_comb begin
      irq_event = `PSC_RST_IRQ;
      irq_event[`PSC_IRQ_TX_CLR] = tx_clr;
      irq_event[`PSC_IRQ_RX_CLR] = rx_clr;
      irq_event[`PSC_IRQ_TX_WRAP] = tx_wrap;
      irq_event[`PSC_IRQ_RX_WRAP] = rx_wrap;
      irq_event[`PSC_IRQ_TX_CRC] = tx_err_inc;
      irq_event[`PSC_IRQ_RX_CRC] = rx_err_inc;
      irq_clear = (wr_done && idx == `PSC_IDX_IRQ_CLEAR && i_pstrb[0]) ?
                  i_pwdata[`PSC_IRQ_W-1:0] : `PSC_RST_IRQ;
      irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         irq_status_reg <= `PSC_RST_IRQ;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         irq_enable_reg <= `PSC_RST_IRQ;
      end else if (wr_done && idx == `PSC_IDX_IRQ_ENABLE && i_pstrb[0]) begin
         irq_enable_reg <= i_pwdata[`PSC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_reg & irq_enable_reg);
      end
   end

   // checks
   upper_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wr_done && idx == `PSC_IDX_DA_UPPER && i_pstrb[1:0] == 2'b11
      |=> ##1 o_match_data[47:32] == $past(i_pwdata[15:0], 2))
      else $error("upper match word not written");

   lower_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wr_done && idx == `PSC_IDX_DA_LOW && i_pstrb[1:0] == 2'b11
      |=> ##1 o_match_data[15:0] == $past(i_pwdata[15:0], 2))
      else $error("lower match word not written");

   tx_low_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready && !i_pwrite && idx == `PSC_IDX_TX_LOW
      |-> o_prdata == {16'h0000, $past(tx_cnt[15:0])})
      else $error("transmit low half read wrong");

   tx_high_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready && !i_pwrite && idx == `PSC_IDX_TX_HIGH
      |-> o_prdata == {16'h0000, $past(tx_cnt[31:16])})
      else $error("transmit high half read wrong");

   tx_crc_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready && !i_pwrite && idx == `PSC_IDX_TX_CRC
      |-> o_prdata == {16'h0000, $past(tx_err_cnt)})
      else $error("transmit crc count read wrong");

   rx_low_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready && !i_pwrite && idx == `PSC_IDX_RX_LOW
      |-> o_prdata == {16'h0000, $past(rx_cnt[15:0])})
      else $error("receive low half read wrong");

   rx_high_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready && !i_pwrite && idx == `PSC_IDX_RX_HIGH
      |-> o_prdata == {16'h0000, $past(rx_cnt[31:16])})
      else $error("receive high half read wrong");

   tx_seq_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_done && idx == `PSC_IDX_TX_SEQ2 && tx_seq_reg == psc_pkg::SEQ_SECOND
      |=> tx_cnt <= 32'h0000_0001 && tx_err_cnt <= 16'h0001)
      else $error("transmit counters not cleared by sequence");

   rx_seq_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_done && idx == `PSC_IDX_RX_SEQ2 && rx_seq_reg == psc_pkg::SEQ_SECOND
      |=> rx_cnt <= 32'h0000_0001 && rx_err_cnt <= 16'h0001)
      else $error("receive counters not cleared by sequence");

   tx_count_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_tx_pkt_done && !tx_clr |=> tx_cnt == $past(tx_cnt) + 32'h0000_0001)
      else $error("transmit count did not step");

   rx_err_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(i_rx_pkt_done && i_rx_pkt_crc_err) && !rx_clr |=> $stable(rx_err_cnt))
      else $error("receive crc count moved without error");

   irq_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      |(irq_status_reg & irq_enable_reg) |=> o_irq)
      else $error("interrupt not raised");

   pready_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready |=> !o_pready)
      else $error("ready held longer than one cycle");

   answer_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      access && !o_pready |=> o_pready)
      else $error("no answer one cycle after access");

   slverr_map_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      access && !o_pready && !mapped |=> o_pready && o_pslverr && o_prdata == `PSC_RST_DATA)
      else $error("unmapped access not refused");

   rx_crc_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pready && !i_pwrite && idx == `PSC_IDX_RX_CRC
      |-> o_prdata == {16'h0000, $past(rx_err_cnt)})
      else $error("receive crc count read wrong");

   rx_count_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rx_pkt_done && !rx_clr |=> rx_cnt == $past(rx_cnt) + 32'h0000_0001)
      else $error("receive count did not step");

   tx_crc_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      tx_err_inc && !tx_clr |=> tx_err_cnt == $past(tx_err_cnt) + 16'h0001)
      else $error("transmit crc count did not step");

   tx_err_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(i_tx_pkt_done && i_tx_pkt_crc_err) && !tx_clr |=> $stable(tx_err_cnt))
      else $error("transmit crc count moved without error");

   da_match_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rx_da_valid && i_rx_da == {da_upper_reg, da_mid_reg, da_low_reg} |=> o_da_match)
      else $error("matching address not flagged");

   da_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !i_rx_da_valid |=> !o_da_match)
      else $error("match flagged without address");

   irq_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wr_done && idx == `PSC_IDX_IRQ_CLEAR && i_pstrb[0] && irq_event == `PSC_RST_IRQ
      |=> (irq_status_reg & $past(i_pwdata[`PSC_IRQ_W-1:0])) == `PSC_RST_IRQ)
      else $error("status bits not cleared");
endmodule
`default_nettype wire

// ### testbench/test_pkt_stats_counters.sv
// self-checking bench for the packet statistics register block
// assumes the bench drives every port itself, apb master and packet events
`include "psc_cfg.svh"
`default_nettype none
module test_pkt_stats_counters;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic wr;
      logic [13:0] idx;
      logic [1:0] lsb;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic err;
   } psc_row_t;
   logic i_clk, i_resetn, i_psel, i_penable, i_pwrite;
   logic [15:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic [3:0] i_pstrb;
   logic o_pready, o_pslverr, o_da_match, o_irq, er;
   logic i_tx_pkt_done, i_tx_pkt_crc_err, i_rx_pkt_done, i_rx_pkt_crc_err, i_rx_da_valid;
   logic [47:0] i_rx_da, o_match_data;
   int miscompares = 0;
   int comparisons = 0;
   // reset values, access kinds and refusals
   psc_row_t rows[17] = '{
      '{1'h0, `PSC_IDX_TX_LOW, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_TX_HIGH, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_TX_CRC, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_RX_LOW, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_RX_HIGH, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_RX_CRC, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_DA_UPPER, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h1, `PSC_IDX_DA_UPPER, 2'h0, 32'hffff_5a3c, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_DA_UPPER, 2'h0, 32'h0, 32'h5a3c, 1'h0},
      '{1'h1, `PSC_IDX_DA_MID, 2'h0, 32'h7e81, 32'h0, 1'h0},
      '{1'h1, `PSC_IDX_DA_LOW, 2'h0, 32'hc3a5, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_DA_LOW, 2'h0, 32'h0, 32'hc3a5, 1'h0},
      '{1'h1, `PSC_IDX_TX_LOW, 2'h0, 32'hffff, 32'h0, 1'h0},
      '{1'h0, `PSC_IDX_TX_LOW, 2'h0, 32'h0, 32'h0, 1'h0},
      '{1'h0, 14'h0100, 2'h0, 32'h0, 32'h0, 1'h1},
      '{1'h0, `PSC_IDX_TX_LOW, 2'h2, 32'h0, 32'h0, 1'h1},
      '{1'h0, `PSC_IDX_IRQ_STATUS, 2'h0, 32'h0, 32'h0, 1'h0}
   };

   psc_regs psc_regs_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_tx_pkt_done(i_tx_pkt_done), .i_tx_pkt_crc_err(i_tx_pkt_crc_err),
      .i_rx_pkt_done(i_rx_pkt_done), .i_rx_pkt_crc_err(i_rx_pkt_crc_err),
      .i_rx_da_valid(i_rx_da_valid), .i_rx_da(i_rx_da), .o_da_match(o_da_match),
      .o_match_data(o_match_data), .o_irq(o_irq));

   task automatic final_report();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_clk);
      i_psel <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite <= wr;
      i_paddr <= addr;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'h1;
      @(posedge i_clk);
      while (o_pready !== 1'h1 && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      if (n == 20) begin
         miscompares++;
         final_report();
      end
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
   endtask

   task automatic rchk(input logic [13:0] idx, input logic [31:0] exp);
      apb(1'h0, {idx, 2'h0}, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wreg(input logic [13:0] idx, input logic [31:0] wd);
      apb(1'h1, {idx, 2'h0}, wd);
   endtask

   task automatic seq3(input logic [13:0] a0, input logic [13:0] a1, input logic [13:0] a2);
      rchk(a0, 32'h0);
      rchk(a1, 32'h0);
      rchk(a2, 32'h0);
   endtask

   // done held high for n edges, n packets in each chosen direction
   task automatic pkts(input logic tx, input logic rx, input logic crc, input int n);
      @(posedge i_clk);
      i_tx_pkt_done <= tx;
      i_rx_pkt_done <= rx;
      i_tx_pkt_crc_err <= crc;
      i_rx_pkt_crc_err <= crc;
      repeat (n) @(posedge i_clk);
      i_tx_pkt_done <= 1'h0;
      i_rx_pkt_done <= 1'h0;
      i_tx_pkt_crc_err <= 1'h0;
      i_rx_pkt_crc_err <= 1'h0;
   endtask

   task automatic da_chk(input logic [47:0] da, input logic exp);
      @(posedge i_clk);
      i_rx_da_valid <= 1'h1;
      i_rx_da <= da;
      @(posedge i_clk);
      i_rx_da_valid <= 1'h0;
      @(negedge i_clk);
      chk(o_da_match, exp);
   endtask

   initial begin
      i_clk = 1'h0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      repeat (80000) @(posedge i_clk);
      miscompares++;
      final_report();
   end

   initial begin
      {i_resetn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
      {i_tx_pkt_done, i_tx_pkt_crc_err, i_rx_pkt_done, i_rx_pkt_crc_err} = '0;
      {i_rx_da_valid, i_rx_da} = '0;
      i_pstrb = 4'hf;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'h1;
      @(negedge i_clk);
      chk({o_pready, o_pslverr, o_irq, o_da_match}, 4'h0);
      chk(o_match_data, 48'h0);
      repeat (2) @(posedge i_clk);
      foreach (rows[k]) begin
         apb(rows[k].wr, {rows[k].idx, rows[k].lsb}, rows[k].wdata);
         chk(er, rows[k].err);
         if (!rows[k].wr) chk(rd, rows[k].rdata);
      end
      chk(o_match_data, 48'h5a3c_7e81_c3a5);
      da_chk(48'h5a3c_7e81_c3a5, 1'h1);
      da_chk(48'h5a3c_7e81_c3a4, 1'h0);
      da_chk(48'h4a3c_7e81_c3a5, 1'h0);
      // low byte lane only
      @(posedge i_clk);
      i_pstrb <= 4'h1;
      wreg(`PSC_IDX_DA_MID, 32'h0000_1234);
      i_pstrb <= 4'hf;
      rchk(`PSC_IDX_DA_MID, 32'h7e34);
      pkts(1'h1, 1'h0, 1'h0, 2);
      pkts(1'h1, 1'h1, 1'h1, 1);
      pkts(1'h0, 1'h1, 1'h1, 1);
      rchk(`PSC_IDX_TX_LOW, 32'h3);
      rchk(`PSC_IDX_TX_CRC, 32'h1);
      rchk(`PSC_IDX_RX_LOW, 32'h2);
      rchk(`PSC_IDX_RX_CRC, 32'h2);
      wreg(`PSC_IDX_IRQ_CLEAR, 32'h3f);
      wreg(`PSC_IDX_IRQ_ENABLE, 32'h1);
      seq3(`PSC_IDX_TX_SEQ1, `PSC_IDX_TX_SEQ0, `PSC_IDX_TX_SEQ2);
      rchk(`PSC_IDX_TX_LOW, 32'h3);
      rchk(`PSC_IDX_TX_SEQ0, 32'h0);
      rchk(`PSC_IDX_TX_LOW, 32'h3);
      rchk(`PSC_IDX_TX_SEQ1, 32'h0);
      rchk(`PSC_IDX_TX_SEQ2, 32'h0);
      rchk(`PSC_IDX_TX_CRC, 32'h1);
      chk(o_irq, 1'h0);
      seq3(`PSC_IDX_TX_SEQ0, `PSC_IDX_TX_SEQ1, `PSC_IDX_TX_SEQ2);
      rchk(`PSC_IDX_TX_LOW, 32'h0);
      rchk(`PSC_IDX_TX_CRC, 32'h0);
      rchk(`PSC_IDX_RX_LOW, 32'h2);
      chk(o_irq, 1'h1);
      rchk(`PSC_IDX_IRQ_STATUS, 32'h1);
      wreg(`PSC_IDX_IRQ_ENABLE, 32'h0);
      repeat (2) @(negedge i_clk);
      chk(o_irq, 1'h0);
      wreg(`PSC_IDX_IRQ_CLEAR, 32'h1);
      rchk(`PSC_IDX_IRQ_STATUS, 32'h0);
      rchk(`PSC_IDX_IRQ_CLEAR, 32'h0);
      seq3(`PSC_IDX_RX_SEQ0, `PSC_IDX_RX_SEQ1, `PSC_IDX_RX_SEQ2);
      rchk(`PSC_IDX_RX_LOW, 32'h0);
      rchk(`PSC_IDX_RX_CRC, 32'h0);
      pkts(1'h1, 1'h1, 1'h0, 65537);
      rchk(`PSC_IDX_TX_LOW, 32'h1);
      rchk(`PSC_IDX_TX_HIGH, 32'h1);
      rchk(`PSC_IDX_RX_LOW, 32'h1);
      rchk(`PSC_IDX_RX_HIGH, 32'h1);
      rchk(`PSC_IDX_TX_CRC, 32'h0);
      // reset in mid-run returns everything to zero
      i_resetn <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'h1;
      @(negedge i_clk);
      chk({o_pready, o_pslverr, o_irq, o_da_match}, 4'h0);
      chk(o_match_data, 48'h0);
      repeat (2) @(posedge i_clk);
      rchk(`PSC_IDX_TX_HIGH, 32'h0);
      rchk(`PSC_IDX_RX_HIGH, 32'h0);
      rchk(`PSC_IDX_DA_UPPER, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
